// ---- verilog/sbc_pkg.sv ----
// Shared constants for the serial bus counter, clock-select and event request block.
// Assumes an 8-bit register port with 32-bit byte addresses, one word per register.
package sbc_pkg;
   // Register byte addresses.
   localparam logic [31:0] SBC_ADDR_IRQ_STATUS  = 32'hfffff3f0;
   localparam logic [31:0] SBC_ADDR_ACK_COUNT   = 32'hfffff3f4;
   localparam logic [31:0] SBC_ADDR_CLK_SEL     = 32'hfffff3f8;
   localparam logic [31:0] SBC_ADDR_FAST_CLK    = 32'hfffff3fc;
   localparam logic [31:0] SBC_ADDR_FRAME_COUNT = 32'hfffff3ec;
   localparam logic [31:0] SBC_ADDR_PENDING     = 32'hfffff3e8;

   // Interrupt status field positions.
   localparam int SBC_ISR_ERR    = 6;
   localparam int SBC_ISR_START  = 5;
   localparam int SBC_ISR_STATUS = 4;
   localparam int SBC_ISR_TRNS   = 3;
   localparam int SBC_ISR_FRAME  = 2;

   // Clock-select field positions and pending-register field positions.
   localparam int SBC_CLK_SEL_BIT   = 0;
   localparam int SBC_FAST_SEL_BIT  = 0;
   localparam int SBC_PEND_TX_BIT   = 0;
   localparam int SBC_PEND_RX_BIT   = 1;
   localparam int SBC_PEND_OVR_BIT  = 2;

   // Reset values and presets.
   localparam logic [7:0] SBC_REG_RESET     = 8'h00;
   localparam logic [7:0] SBC_FRAME_PRESET  = 8'h20;
   localparam logic [8:0] SBC_ACK_RESET     = 9'h001;
   localparam logic [7:0] SBC_READ_UNMAPPED = 8'h00;

   // Bus-timing divide multipliers relative to the 6 MHz base.
   localparam logic [1:0] SBC_MULT_STOP = 2'h0;
   localparam logic [1:0] SBC_MULT_6M   = 2'h1;
   localparam logic [1:0] SBC_MULT_12M  = 2'h2;
   localparam logic [1:0] SBC_MULT_18M  = 2'h3;

   // Main clock range selected by the two select bits.
   typedef enum logic [1:0] {SBC_RANGE_6M, SBC_RANGE_12M, SBC_RANGE_18M, SBC_RANGE_BAD} sbc_range_t;
endpackage

// ---- verilog/sbc_cnt_if.sv ----
// Interface between the top level and one preset-and-decrement byte counter.
// Assumes both ends run on sys_clk.
`timescale 1ns/1ns
interface sbc_cnt_if #(parameter int W = 8);
   logic         load;
   logic [W-1:0] load_val;
   logic         dec;
   logic [W-1:0] count;
   logic         zero_hit;

   modport ctl (output load, output load_val, output dec, input count, input zero_hit);
   modport cnt (input load, input load_val, input dec, output count, output zero_hit);
endinterface

// ---- verilog/sbc_down_counter.sv ----
// Preset-and-decrement byte counter with a pulse when it steps onto zero.
// Assumes load and dec come from logic on sys_clk; load beats dec.
`timescale 1ns/1ns
module sbc_down_counter #(
   parameter int         W         = 8,
   parameter logic [W-1:0] RESET_VAL = '0
) (
   input  wire logic sys_clk,
   input  wire logic sys_rst,
   sbc_cnt_if.cnt    bus
);
   logic [W-1:0] count_reg;
   logic [W-1:0] count_next;
   logic         at_one;

   // A count already at zero holds, so a stray decrement never wraps to all ones.
   assign at_one     = (count_reg == W'(1));
   assign count_next = bus.load ? bus.load_val :
                       ((bus.dec && count_reg != '0) ? count_reg - W'(1) : count_reg);
   assign bus.count    = count_reg;
   assign bus.zero_hit = bus.dec && !bus.load && at_one;

   // Count register.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         count_reg <= RESET_VAL;
      end else begin
         count_reg <= count_next;
      end
   end
endmodule

// ---- verilog/sbc_bus_timer.sv ----
// Bus-timing tick generator: one tick per BASE_DIV * mult main-clock cycles.
// Assumes mult is steady from logic on sys_clk; zero stops the tick.
`timescale 1ns/1ns
module sbc_bus_timer #(
   parameter int BASE_DIV = 6
) (
   input  wire logic       sys_clk,
   input  wire logic       sys_rst,
   input  wire logic [1:0] mult,
   output logic            tick
);
   logic [7:0] div_reg;
   logic [7:0] div_next;
   logic [7:0] limit;
   logic       wrap;

   // A faster main clock needs a longer divide so the bus bit time stays the same.
   assign limit    = 8'(BASE_DIV * int'(mult) - 1);
   assign wrap     = (mult != 2'h0) && (div_reg >= limit);
   assign div_next = (mult == 2'h0 || wrap) ? 8'h00 : div_reg + 8'h01;

   // Divider and registered tick.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         div_reg <= 8'h00;
         tick    <= 1'b0;
      end else begin
         div_reg <= div_next;
         tick    <= wrap;
      end
   end
endmodule

// ---- verilog/sbc_top.sv ----
// Byte counters, bus clock selection and event request gathering of the serial bus controller.
// Assumes event inputs come from the protocol engine on sys_clk as one-cycle pulses.
`timescale 1ns/1ns
module sbc_top
   import sbc_pkg::*;
#(
   parameter int BASE_DIV = 6
) (
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   input  wire logic [31:0] reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   input  wire logic        frame_start,
   input  wire logic [7:0]  telegraph_len,
   input  wire logic        byte_done,
   input  wire logic        byte_acked,
   input  wire logic        in_data_field,
   input  wire logic        timing_err,
   input  wire logic        parity_err,
   input  wire logic        nack_rx,
   input  wire logic        underrun_err,
   input  wire logic        master_req,
   input  wire logic        lost_contention,
   input  wire logic        addr_phase,
   input  wire logic        slave_req_hit,
   input  wire logic        control_field,
   input  wire logic        slave_status_req,
   input  wire logic        nack_sent_ctrl,
   input  wire logic        tx_to_shifter,
   input  wire logic        tx_last_byte,
   input  wire logic        rx_byte_ok,
   input  wire logic        data_reg_wr,
   input  wire logic        data_reg_rd,
   output logic             dma_request_line,
   output logic             vector_request_line,
   output logic             bus_tick,
   output logic             clock_cfg_bad,
   output logic             overrun_state
);
   sbc_cnt_if #(.W(8)) frame_bus ();
   sbc_cnt_if #(.W(9)) ack_bus ();

   logic [7:0] bus_clock_select_reg;
   logic [7:0] fast_clock_select_reg;
   logic [7:0] irq_status_reg;
   logic [7:0] irq_status_next;
   logic       tx_word_pending_reg;
   logic       rx_word_pending_reg;
   logic       overrun_reg;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;

   // Address decode, one wire per register.
   wire hit_isr   = (reg_addr == SBC_ADDR_IRQ_STATUS);
   wire hit_ack   = (reg_addr == SBC_ADDR_ACK_COUNT);
   wire hit_clk   = (reg_addr == SBC_ADDR_CLK_SEL);
   wire hit_fast  = (reg_addr == SBC_ADDR_FAST_CLK);
   wire hit_frame = (reg_addr == SBC_ADDR_FRAME_COUNT);
   wire hit_pend  = (reg_addr == SBC_ADDR_PENDING);

   // Clock range from the two select bits.
   wire clock_select_low  = bus_clock_select_reg[SBC_CLK_SEL_BIT];
   wire clock_select_high = fast_clock_select_reg[SBC_FAST_SEL_BIT];
   sbc_range_t range;
   logic [1:0] mult;

   // The prohibited combination stops the tick rather than guess a rate.
   assign range = sbc_range_t'({clock_select_high, clock_select_low});
   always_comb begin
      mult = SBC_MULT_STOP;
      unique case (range)
         SBC_RANGE_6M:  mult = SBC_MULT_6M;
         SBC_RANGE_12M: mult = SBC_MULT_12M;
         SBC_RANGE_18M: mult = SBC_MULT_18M;
         SBC_RANGE_BAD: mult = SBC_MULT_STOP;
      endcase
   end
   assign clock_cfg_bad = (range == SBC_RANGE_BAD);

   sbc_bus_timer #(.BASE_DIV(BASE_DIV)) u_timer (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .mult    (mult),
      .tick    (bus_tick)
   );

   // Frame counter: preset every frame, steps on every byte whatever its acknowledge.
   assign frame_bus.load     = frame_start;
   assign frame_bus.load_val = SBC_FRAME_PRESET;
   assign frame_bus.dec      = byte_done;

   // The success counter is nine bits wide so a length of 00H means 256 bytes.
   assign ack_bus.load     = frame_start;
   assign ack_bus.load_val = {telegraph_len == 8'h00, telegraph_len};
   assign ack_bus.dec      = byte_done && byte_acked && in_data_field;

   sbc_down_counter #(.W(8), .RESET_VAL(SBC_FRAME_PRESET)) u_frame_cnt (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .bus     (frame_bus)
   );

   sbc_down_counter #(.W(9), .RESET_VAL(SBC_ACK_RESET)) u_ack_cnt (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .bus     (ack_bus)
   );

   // Overrun: a good byte arrives while the previous one still waits for a read.
   wire overrun_entry = rx_byte_ok && rx_word_pending_reg && !data_reg_rd;
   wire rx_accept     = rx_byte_ok && !overrun_reg && !overrun_entry;

   // Event sources feeding the status flags.
   wire ev_err    = timing_err || parity_err || nack_rx || underrun_err || overrun_entry;
   wire ev_start  = addr_phase && ((master_req && lost_contention) ||
                                   (!master_req && slave_req_hit));
   wire ev_status = control_field && (slave_status_req || nack_sent_ctrl);
   wire ev_trns   = in_data_field && ack_bus.zero_hit;
   wire ev_frame  = frame_bus.zero_hit;

   wire [7:0] ev_vec = 8'(({7'h00, ev_err}    << SBC_ISR_ERR)    |
                          ({7'h00, ev_start}  << SBC_ISR_START)  |
                          ({7'h00, ev_status} << SBC_ISR_STATUS) |
                          ({7'h00, ev_trns}   << SBC_ISR_TRNS)   |
                          ({7'h00, ev_frame}  << SBC_ISR_FRAME));
   wire [7:0] isr_mask = ev_vec | 8'(8'h01 << SBC_ISR_ERR) | 8'(8'h01 << SBC_ISR_START) |
                         8'(8'h01 << SBC_ISR_STATUS) | 8'(8'h01 << SBC_ISR_TRNS) |
                         8'(8'h01 << SBC_ISR_FRAME);

   // Write-one-to-clear, and a new event in the same cycle keeps its bit set.
   wire [7:0] isr_clear = (reg_wr && hit_isr) ? reg_wdata : 8'h00;
   assign irq_status_next = ((irq_status_reg & ~isr_clear) | ev_vec) & isr_mask;

   // Status flags.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         irq_status_reg <= SBC_REG_RESET;
      end else begin
         irq_status_reg <= irq_status_next;
      end
   end

   // Pending data flags; the request edge beats the data-register access that clears it.
   wire tx_set  = tx_to_shifter && !tx_last_byte;
   wire rx_set  = rx_accept;
   wire tx_next = tx_set || (tx_word_pending_reg && !data_reg_wr);
   wire rx_next = rx_set || (rx_word_pending_reg && !data_reg_rd);
   wire ov_next = overrun_entry || (overrun_reg && !data_reg_rd);

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         tx_word_pending_reg <= 1'b0;
         rx_word_pending_reg <= 1'b0;
         overrun_reg         <= 1'b0;
      end else begin
         tx_word_pending_reg <= tx_next;
         rx_word_pending_reg <= rx_next;
         overrun_reg         <= ov_next;
      end
   end

   // Clock-select registers keep only bit 0, so the unused bits can never read back set.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         bus_clock_select_reg  <= SBC_REG_RESET;
         fast_clock_select_reg <= SBC_REG_RESET;
      end else begin
         if (reg_wr && hit_clk) begin
            bus_clock_select_reg <= reg_wdata & 8'h01;
         end
         if (reg_wr && hit_fast) begin
            fast_clock_select_reg <= reg_wdata & 8'h01;
         end
      end
   end

   // Read mux; the counters are read-only and an unmapped address reads zero.
   wire [7:0] pend_vec = 8'(({7'h00, tx_word_pending_reg} << SBC_PEND_TX_BIT) |
                            ({7'h00, rx_word_pending_reg} << SBC_PEND_RX_BIT) |
                            ({7'h00, overrun_reg}         << SBC_PEND_OVR_BIT));
   assign rdata_next = !reg_rd   ? SBC_READ_UNMAPPED :
                       hit_isr   ? irq_status_reg :
                       hit_ack   ? ack_bus.count[7:0] :
                       hit_clk   ? bus_clock_select_reg :
                       hit_fast  ? fast_clock_select_reg :
                       hit_frame ? frame_bus.count :
                       hit_pend  ? pend_vec : SBC_READ_UNMAPPED;

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rdata_reg <= SBC_READ_UNMAPPED;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   // Request outputs.
   assign reg_rdata           = rdata_reg;
   assign dma_request_line    = tx_word_pending_reg || rx_word_pending_reg;
   assign vector_request_line = |irq_status_reg;
   assign overrun_state       = overrun_reg;

   // Checks on the guarded logic; they all run on sys_clk and sleep while reset is high.
   default clocking chk_clk @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);

   // A frame start always lands the preset.
   a_frame_preset: assert property (
      frame_start |=> frame_bus.count == SBC_FRAME_PRESET)
      else $error("frame counter not preset");

   // Every byte outside a frame start steps a nonzero frame counter down by one.
   a_frame_step: assert property (
      byte_done && !frame_start && frame_bus.count != 8'h00 |=> frame_bus.count == $past(frame_bus.count) - 8'h01)
      else $error("frame counter did not step");

   // The last byte of a frame empties the counter and raises the frame end flag.
   a_frame_end: assert property (
      byte_done && !frame_start && frame_bus.count == 8'h01 |=>
      frame_bus.count == 8'h00 && irq_status_reg[SBC_ISR_FRAME])
      else $error("frame end flag missing");

   // A byte that is not an acked data byte leaves the success counter alone.
   a_ack_hold: assert property (
      !frame_start && !(byte_done && byte_acked && in_data_field) |=> $stable(ack_bus.count))
      else $error("success counter moved without ack");

   // An acked data byte takes exactly one off the success counter.
   a_ack_step: assert property (
      ack_bus.dec && !frame_start && ack_bus.count != 9'h000 |=> ack_bus.count == $past(ack_bus.count) - 9'h001)
      else $error("success counter did not step");

   // Both select bits set is flagged and stops the divide.
   a_clk_range: assert property (
      clock_select_high && clock_select_low |-> clock_cfg_bad && mult == SBC_MULT_STOP)
      else $error("prohibited clock select not flagged");

   // No tick leaves the timer while the setting is prohibited.
   a_tick_stop: assert property (
      clock_cfg_bad |=> !bus_tick)
      else $error("tick under prohibited clock select");

   // Any error source sets the error flag and the vector request.
   a_err_set: assert property (
      (timing_err || parity_err || nack_rx || underrun_err) |=> irq_status_reg[SBC_ISR_ERR] && vector_request_line)
      else $error("error flag missing");

   // Losing contention in the address phase while asking for mastership always raises start.
   a_start_lost: assert property (
      addr_phase && master_req && lost_contention |=> irq_status_reg[SBC_ISR_START])
      else $error("start flag missing on lost contention");

   // As a slave, start stays low unless a slave request addresses the unit.
   a_start_slave: assert property (
      !irq_status_reg[SBC_ISR_START] && !master_req && !slave_req_hit |=> !irq_status_reg[SBC_ISR_START])
      else $error("start flag without slave request");

   // A status request or a returned NACK in the control field raises status.
   a_status_set: assert property (
      control_field && (slave_status_req || nack_sent_ctrl) |=> irq_status_reg[SBC_ISR_STATUS])
      else $error("status flag missing");

   // The success counter stepping onto zero ends the communication.
   a_trns_set: assert property (
      ack_bus.dec && !frame_start && ack_bus.count == 9'h001 |=> irq_status_reg[SBC_ISR_TRNS])
      else $error("end of communication flag missing");

   // Outside the data field the end-of-communication flag cannot rise.
   a_trns_field: assert property (
      !in_data_field && !irq_status_reg[SBC_ISR_TRNS] |=> !irq_status_reg[SBC_ISR_TRNS])
      else $error("end of communication outside data field");

   // A clear written in the cycle of a new frame end must lose.
   a_isr_set_wins: assert property (
      ev_frame && reg_wr && hit_isr |=> irq_status_reg[SBC_ISR_FRAME])
      else $error("clear beat a new event");

   // A byte moved to the shifter asks for the next one.
   a_dma_or: assert property (
      tx_to_shifter && !tx_last_byte |=> dma_request_line [*1] ##0 tx_word_pending_reg)
      else $error("transmit request missing");

   // A good received byte raises the DMA request.
   a_dma_rx: assert property (
      rx_byte_ok && !rx_word_pending_reg && !overrun_reg |=> dma_request_line)
      else $error("receive DMA request missing");

   // The last byte never asks for more data.
   a_tx_last: assert property (
      tx_to_shifter && tx_last_byte && !tx_word_pending_reg |=> !tx_word_pending_reg)
      else $error("request after last byte");

   // A good byte with room for it is announced.
   a_rx_ready: assert property (
      rx_byte_ok && !rx_word_pending_reg && !overrun_reg |=> rx_word_pending_reg)
      else $error("receive request missing");

   // Only a data register read ends the overrun state.
   a_overrun_hold: assert property (
      overrun_reg && !data_reg_rd |=> overrun_reg)
      else $error("overrun left without read");

   // The select registers never hold anything above bit 0.
   a_clk_zero: assert property (
      bus_clock_select_reg[7:1] == 7'h00 && fast_clock_select_reg[7:1] == 7'h00)
      else $error("clock select upper bits set");

   // A read of the clock select returns the stored value one cycle later.
   a_read_late: assert property (
      reg_rd && hit_clk |=> reg_rdata == $past(bus_clock_select_reg))
      else $error("bad clock select read");

   // Main scenarios that the bench is meant to reach.
   c_frame_end:   cover property (ev_frame);
   c_trns_end:    cover property (ev_trns);
   c_overrun:     cover property (overrun_entry);
   c_fast_clock:  cover property (range == SBC_RANGE_18M && bus_tick);
   c_slave_start: cover property (ev_start && !master_req);
endmodule

// ---- test/sbc_bus_peer.sv ----
// Model of the other units on the serial bus: sends a burst of bytes, all acked or all refused.
// Assumes send is a one-cycle pulse on sys_clk and n_bytes, ack_all are steady with it.
`timescale 1ns/1ns
module sbc_bus_peer (
   input  wire logic       sys_clk,
   input  wire logic       sys_rst,
   input  wire logic       send,
   input  wire logic [7:0] n_bytes,
   input  wire logic       ack_all,
   output logic            byte_done,
   output logic            byte_acked,
   output logic            busy
);
   logic [7:0] left_reg;
   logic [1:0] gap_reg;

   assign busy = (left_reg != 8'h00);

   // One byte every four cycles; the ack line toggles between bytes so a stale value never passes.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         left_reg   <= 8'h00;
         gap_reg    <= 2'h0;
         byte_done  <= 1'b0;
         byte_acked <= 1'b0;
      end else begin
         byte_done  <= 1'b0;
         byte_acked <= ~byte_acked;
         if (send) begin
            left_reg <= n_bytes;
            gap_reg  <= 2'h3;
         end else if (busy && gap_reg == 2'h0) begin
            byte_done  <= 1'b1;
            byte_acked <= ack_all;
            left_reg   <= left_reg - 8'h01;
            gap_reg    <= 2'h3;
         end else if (busy) begin
            gap_reg <= gap_reg - 2'h1;
         end
      end
   end
endmodule

// ---- test/sbc_top_tb.sv ----
// Self-checking bench for sbc_top: register port, byte counters, event flags and bus tick.
// Assumes sbc_pkg and sbc_bus_peer are compiled first; BASE_DIV is shortened to 2.
`timescale 1ns/1ns
module sbc_top_tb;
   import sbc_pkg::*;
   localparam int BDIV = 2;
   localparam logic [11:0] E_FS = 12'h001, E_LOST = 12'h020, E_SSR = 12'h040, E_NCT = 12'h080;
   localparam logic [11:0] E_TX = 12'h100, E_RX = 12'h200, E_DWR = 12'h400, E_DRD = 12'h800;
   localparam logic [5:0]  L_DF = 6'h01, L_MR = 6'h02, L_AP = 6'h04, L_HIT = 6'h08, L_CF = 6'h10, L_LAST = 6'h20;
   logic        sys_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, send = 1'b0, ack_all = 1'b0;
   logic [31:0] reg_addr = 32'h0;
   logic [7:0]  reg_wdata = 8'h00, telegraph_len = 8'h00, n_bytes = 8'h00, reg_rdata;
   logic [11:0] ev = 12'h000;
   logic [5:0]  lv = 6'h00;
   logic        byte_done, byte_acked, busy, dma_request_line, vector_request_line, bus_tick, cfg_bad, ovr;
   int          error_cnt = 0, n_compared = 0;

   // Half period of 10 ns gives the 50 MHz system clock.
   always #10 sys_clk = ~sys_clk;

   sbc_bus_peer i_sbc_bus_peer (.sys_clk(sys_clk), .sys_rst(sys_rst), .send(send), .n_bytes(n_bytes),
      .ack_all(ack_all), .byte_done(byte_done), .byte_acked(byte_acked), .busy(busy));

   sbc_top #(.BASE_DIV(BDIV)) i_sbc_top (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame_start(ev[0]),
      .telegraph_len(telegraph_len), .byte_done(byte_done), .byte_acked(byte_acked), .in_data_field(lv[0]),
      .timing_err(ev[1]), .parity_err(ev[2]), .nack_rx(ev[3]), .underrun_err(ev[4]), .master_req(lv[1]),
      .lost_contention(ev[5]), .addr_phase(lv[2]), .slave_req_hit(lv[3]), .control_field(lv[4]),
      .slave_status_req(ev[6]), .nack_sent_ctrl(ev[7]), .tx_to_shifter(ev[8]), .tx_last_byte(lv[5]),
      .rx_byte_ok(ev[9]), .data_reg_wr(ev[10]), .data_reg_rd(ev[11]), .dma_request_line(dma_request_line),
      .vector_request_line(vector_request_line), .bus_tick(bus_tick), .clock_cfg_bad(cfg_bad),
      .overrun_state(ovr));

   // The single place where the run ends.
   task automatic wrap_up;
      $display("compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask

   function automatic logic [7:0] bv(input int p);
      return 8'h01 << p;
   endfunction

   // Register port: one-cycle strobes, read data taken in the cycle after the strobe.
   task automatic wr(input logic [31:0] a, input logic [7:0] v);
      @(posedge sys_clk);
      reg_addr <= a; reg_wdata <= v; reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      #1;
   endtask

   task automatic rchk(input logic [31:0] a, input logic [7:0] e);
      @(posedge sys_clk);
      reg_addr <= a; reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
   endtask

   // An event is high for exactly one sampling edge; its effect is visible on return.
   task automatic pulse(input logic [11:0] m);
      @(posedge sys_clk);
      ev <= m;
      @(posedge sys_clk);
      ev <= 12'h000;
      #1;
   endtask

   task automatic setlv(input logic [5:0] v);
      @(posedge sys_clk);
      lv <= v;
   endtask

   // Ask the peer for a burst and wait, bounded, until its last byte has been counted.
   task automatic burst(input logic [7:0] n, input logic a);
      int i;
      @(posedge sys_clk);
      n_bytes <= n; ack_all <= a; send <= 1'b1;
      @(posedge sys_clk);
      send <= 1'b0;
      #1;
      for (i = 0; i < 400 && (busy || byte_done); i++) begin @(posedge sys_clk); #1; end
      if (i == 400) begin error_cnt++; wrap_up(); end
   endtask

   // Skip two ticks so a change of divide settles, then measure one full gap.
   task automatic tick_gap(input logic [7:0] e);
      int n, k;
      for (k = 0; k < 3; k++) begin
         n = 0;
         do begin @(posedge sys_clk); #1; n++; end while (bus_tick !== 1'b1 && n < 60);
      end
      chk(8'(n), e);
   endtask

   task automatic sc_clock;
      int n;
      rchk(SBC_ADDR_CLK_SEL, 8'h00);
      tick_gap(8'(BDIV));
      wr(SBC_ADDR_CLK_SEL, 8'hff);                   // Software matches the select to the main clock.
      rchk(SBC_ADDR_CLK_SEL, 8'h01);
      tick_gap(8'(2 * BDIV));
      wr(SBC_ADDR_CLK_SEL, 8'h00);
      wr(SBC_ADDR_FAST_CLK, 8'h01);
      tick_gap(8'(3 * BDIV));
      wr(SBC_ADDR_CLK_SEL, 8'h01);
      n = 0;
      repeat (40) begin @(posedge sys_clk); #1; if (bus_tick === 1'b1) n++; end
      chk({7'h0, cfg_bad}, 8'h01);
      chk(8'(n), 8'h00);
      wr(SBC_ADDR_FAST_CLK, 8'h00);
      rchk(32'hfffff300, SBC_READ_UNMAPPED);         // Unmapped place reads as zero.
   endtask

   task automatic sc_frame;
      pulse(E_FS);
      rchk(SBC_ADDR_FRAME_COUNT, SBC_FRAME_PRESET);
      burst(8'd16, 1'b1);
      burst(8'd15, 1'b0);
      rchk(SBC_ADDR_FRAME_COUNT, 8'h01);
      rchk(SBC_ADDR_IRQ_STATUS, 8'h00);
      burst(8'd1, 1'b0);
      rchk(SBC_ADDR_FRAME_COUNT, 8'h00);
      rchk(SBC_ADDR_IRQ_STATUS, bv(SBC_ISR_FRAME));
      chk({7'h0, vector_request_line}, 8'h01);
      wr(SBC_ADDR_IRQ_STATUS, bv(SBC_ISR_FRAME));
      chk({7'h0, vector_request_line}, 8'h00);
   endtask

   task automatic sc_success;
      telegraph_len <= 8'h02;
      setlv(L_DF);
      pulse(E_FS);
      burst(8'd1, 1'b0);
      rchk(SBC_ADDR_ACK_COUNT, 8'h02);
      burst(8'd2, 1'b1);
      rchk(SBC_ADDR_ACK_COUNT, 8'h00);
      rchk(SBC_ADDR_IRQ_STATUS, bv(SBC_ISR_TRNS));
      wr(SBC_ADDR_IRQ_STATUS, bv(SBC_ISR_TRNS));
      setlv(6'h00);
   endtask

   task automatic sc_errors;
      for (int i = 1; i < 5; i++) begin
         pulse(12'h001 << i);
         rchk(SBC_ADDR_IRQ_STATUS, bv(SBC_ISR_ERR));
         chk({7'h0, vector_request_line}, 8'h01);
         wr(SBC_ADDR_IRQ_STATUS, bv(SBC_ISR_ERR));
      end
      // A clear that meets a new error in the same cycle must lose.
      @(posedge sys_clk);
      ev <= 12'h002;
      reg_addr <= SBC_ADDR_IRQ_STATUS;
      reg_wdata <= bv(SBC_ISR_ERR);
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      ev <= 12'h000;
      reg_wr <= 1'b0;
      rchk(SBC_ADDR_IRQ_STATUS, bv(SBC_ISR_ERR));
      wr(SBC_ADDR_IRQ_STATUS, bv(SBC_ISR_ERR));
   endtask

   task automatic sc_start_status;
      setlv(L_MR | L_AP);
      pulse(E_LOST);
      setlv(L_AP);
      setlv(6'h00);
      rchk(SBC_ADDR_IRQ_STATUS, bv(SBC_ISR_START));
      wr(SBC_ADDR_IRQ_STATUS, bv(SBC_ISR_START));
      setlv(L_AP | L_HIT);
      setlv(6'h00);
      rchk(SBC_ADDR_IRQ_STATUS, bv(SBC_ISR_START));
      wr(SBC_ADDR_IRQ_STATUS, bv(SBC_ISR_START));
      setlv(L_CF);
      pulse(E_SSR);
      rchk(SBC_ADDR_IRQ_STATUS, bv(SBC_ISR_STATUS));
      wr(SBC_ADDR_IRQ_STATUS, bv(SBC_ISR_STATUS));
      pulse(E_NCT);
      rchk(SBC_ADDR_IRQ_STATUS, bv(SBC_ISR_STATUS));
      wr(SBC_ADDR_IRQ_STATUS, bv(SBC_ISR_STATUS));
      setlv(6'h00);
   endtask

   task automatic sc_dma;
      pulse(E_TX);
      chk({7'h0, dma_request_line}, 8'h01);
      pulse(E_DWR);
      chk({7'h0, dma_request_line}, 8'h00);
      setlv(L_LAST);
      pulse(E_TX);
      chk({7'h0, dma_request_line}, 8'h00);
      setlv(6'h00);
      pulse(E_RX);
      chk({7'h0, dma_request_line}, 8'h01);
      pulse(E_RX);
      chk({7'h0, ovr}, 8'h01);
      rchk(SBC_ADDR_IRQ_STATUS, bv(SBC_ISR_ERR));
      rchk(SBC_ADDR_PENDING, 8'h06);
      pulse(E_DWR);
      chk({7'h0, ovr}, 8'h01);
      pulse(E_DRD);
      chk({7'h0, ovr}, 8'h00);
      rchk(SBC_ADDR_PENDING, 8'h00);
   endtask

   // Main sequence: reset for ten cycles, then each scenario in turn.
   initial begin
      repeat (10) @(posedge sys_clk);
      sys_rst <= 1'b0;
      sc_clock();
      sc_frame();
      sc_success();
      sc_errors();
      sc_start_status();
      sc_dma();
      wrap_up();
   end
endmodule
